//--- core/sfp_pkg.sv
`default_nettype none
package sfp_pkg;
   // ------------------------------------------------------------
   // array geometry
   // ------------------------------------------------------------
   localparam int ARRAY_BYTES = 4194304;
   localparam int SUBSECTOR_BYTES = 4096;
   localparam int SECTOR_BYTES = 65536;
   localparam int PAGE_BYTES = 256;
   localparam int SECTOR_COUNT = 64;
   localparam int SUBSECTOR_COUNT = 1024;
   localparam int PAGE_COUNT = 16384;
   localparam int OTP_BYTES = 64;
   localparam int ADDR_W = 22;
   localparam int SECT_LSB = 16;
   localparam int SECT_MSB = 21;
   localparam int SECT_W = 7;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   // ------------------------------------------------------------
   // protect levels and timing
   // ------------------------------------------------------------
   localparam logic [2:0] LEVEL_NONE = 3'h0;
   localparam logic [2:0] LEVEL_ALL = 3'h7;
   localparam int SYNC_STAGES = 2;
   // operation codes presented on the user side
   typedef enum logic [1:0] {
      SFP_OP_PROGRAM,
      SFP_OP_SECTOR_ERASE,
      SFP_OP_BULK_ERASE,
      SFP_OP_NONE
   } sfp_op_type;
endpackage
`default_nettype wire

//--- core/sfp_guard.sv
`default_nettype none
// ------------------------------------------------------------
// guarded span decoder
// ------------------------------------------------------------
module sfp_guard #(
   parameter int SECTORS = 64
) (
   input wire logic top_bottom,
   input wire logic [2:0] level,
   input wire logic [6:0] sector,
   output logic guarded
);
   initial begin
      if (SECTORS != 64 && SECTORS != 128) begin
         $error("sfp_guard: SECTORS must be 64 or 128");
      end
   end
   logic [7:0] span;
   always_comb begin
      span = 8'h00;
      guarded = 1'b0;
      if (level != sfp_pkg::LEVEL_NONE) begin
         // span doubles per level: 1,2,4,... for 64 sectors
         span = 8'(8'h01 << (level - 3'h1));
         if (SECTORS == 128) begin
            span = 8'(span << 1);
         end
         if (level == sfp_pkg::LEVEL_ALL) begin
            guarded = (SECTORS == 64) || !top_bottom;
            // lower 128-sector table leaves 111 unguarded
         end else if (!top_bottom) begin
            guarded = ({1'b0, sector} >= 8'(SECTORS) - span);
         end else begin
            guarded = ({1'b0, sector} < span);
         end
      end
   end
endmodule
`default_nettype wire

//--- core/sfp_sync.sv
`default_nettype none
// ------------------------------------------------------------
// two flop synchroniser
// ------------------------------------------------------------
module sfp_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r;
   // first stage read only by second
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= INIT;
         q <= INIT;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire

//--- core/sfp_top.sv
`default_nettype none
// Notes on behaviour
// - top selector 0, 64 sectors: levels 001-011 guard sector 63, 62-63, 60-63.
// - top selector 0: levels 100-110 guard 56-63, 48-63, 32-63; 111 guards all.
// - top selector 1: levels 001-011 guard sector 0, 0-1, 0-3.
// - top selector 1: levels 100-110 guard 0-7, 0-15, 0-31; 111 guards all.
// - bulk erase accepted only with all protect level bits zero.
// - optional 128 sectors, top: levels 001-110 guard nothing, as sector stays 0-63; 111 all.
// - optional 128 sectors, bottom: 0-1 up to 0-63 at level 110.
// - pause freezes serial traffic, never aborts a running internal cycle.
// - pause begins at pause fall if clock low, else at next clock fall.
// - pause ends at pause rise if clock low, else at next clock fall.
// - paused: data output floats, data input and clock ignored.
// - paused with select low: all interface state preserved.
// - select rising while paused resets the interface logic.
// - program only clears bits, page by page.
// - erase per sector or whole array returns bits to one.
// - array is 4 MB: 1024 subsectors, 64 sectors, 16384 pages.
// - separate 64 byte one-time area outside the main array.
// - array access ignored while an internal cycle runs.
// - bytes travel most significant bit first both ways.
module sfp_top #(
   parameter int SECTORS = 64
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clk_en,
   // serial pins, sampled on core_clk
   input wire logic sel_n,
   input wire logic sclk,
   input wire logic pause_n,
   input wire logic serial_data_in,
   output logic serial_data_out,
   output logic serial_data_out_oe,
   // status bits
   input wire logic top_bottom,
   input wire logic protect_level_msb,
   input wire logic protect_level_mid,
   input wire logic protect_level_lsb,
   input wire logic busy,
   input wire logic [7:0] tx_byte,
   // user side of the decoded transfer
   input wire logic op_valid,
   input wire sfp_pkg::sfp_op_type op_kind,
   input wire logic [sfp_pkg::ADDR_W-1:0] op_addr,
   output logic op_accept,
   output logic op_refuse,
   output logic paused,
   output logic [7:0] rx_byte,
   output logic rx_valid,
   output logic [2:0] bit_count
);
   initial begin
      if (SECTORS != 64 && SECTORS != 128) begin
         $error("sfp_top: SECTORS must be 64 or 128");
      end
   end

   // ------------------------------------------------------------
   // reset release and pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] rst_sh_r;
   logic rst_n;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst_sh_r <= 2'h0;
      end else begin
         rst_sh_r <= {rst_sh_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sh_r[1];

   logic sel_n_s, sclk_s, pause_n_s, din_s;
   // idle levels: deselected, clock low, pause released, data low; avoids a false edge after reset
   sfp_sync #(.WIDTH(4), .INIT(4'hA)) u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .d({sel_n, sclk, pause_n, serial_data_in}),
      .q({sel_n_s, sclk_s, pause_n_s, din_s})
   );

   // edge detect on synchronised copies only
   logic sclk_d_r, pause_n_d_r, sel_n_d_r;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_d_r <= 1'b0;
         pause_n_d_r <= 1'b1;
         sel_n_d_r <= 1'b1;
      end else if (clk_en) begin
         sclk_d_r <= sclk_s;
         pause_n_d_r <= pause_n_s;
         sel_n_d_r <= sel_n_s;
      end
   end
   logic sclk_rise, sclk_fall, sel_rise, sel_fall;
   assign sclk_rise = sclk_s && !sclk_d_r;
   assign sclk_fall = !sclk_s && sclk_d_r;
   assign sel_rise = sel_n_s && !sel_n_d_r;
   assign sel_fall = !sel_n_s && sel_n_d_r;

   // ------------------------------------------------------------
   // pause condition
   // ------------------------------------------------------------
   logic paused_r, paused_nxt;
   always_comb begin
      paused_nxt = paused_r;
      if (sel_n_s) begin
         paused_nxt = 1'b0;
      end else if (!sclk_s) begin
         // leave when clock low
         // a pending edge resolves at the next clock fall, which is low here
         paused_nxt = !pause_n_s;
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         paused_r <= 1'b0;
      end else if (clk_en) begin
         paused_r <= paused_nxt;
      end
   end

   // ------------------------------------------------------------
   // serial shift engine
   // ------------------------------------------------------------
   logic [2:0] bit_cnt_r;
   logic [7:0] rx_sh_r, tx_sh_r;
   logic rx_valid_r, dout_r, oe_r;
   logic active;
   // clock and data ignored while paused
   assign active = !sel_n_s && !paused_r;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt_r <= 3'h0;
         rx_sh_r <= 8'h00;
         rx_valid_r <= 1'b0;
      end else if (clk_en) begin
         rx_valid_r <= 1'b0;
         if (sel_n_s) begin
            bit_cnt_r <= 3'h0;
            rx_sh_r <= 8'h00;
         end else if (active && sclk_rise) begin
            rx_sh_r <= {rx_sh_r[6:0], din_s};
            bit_cnt_r <= bit_cnt_r + 3'h1;
            rx_valid_r <= (bit_cnt_r == 3'h7);
         end
      end
   end

   // output shifter advances on falling clock
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_sh_r <= 8'h00;
         dout_r <= 1'b0;
      end else if (clk_en) begin
         if (sel_fall || (active && sclk_fall && bit_cnt_r == 3'h0)) begin
            tx_sh_r <= {tx_byte[6:0], 1'b0};
            dout_r <= tx_byte[7];
         end else if (active && sclk_fall) begin
            dout_r <= tx_sh_r[7];
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
         end
      end
   end

   // output floats while paused or deselected
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         oe_r <= 1'b0;
      end else if (clk_en) begin
         oe_r <= !sel_n_s && !paused_nxt;
      end
   end

   // ------------------------------------------------------------
   // guard and operation gate
   // ------------------------------------------------------------
   logic [2:0] level;
   logic [6:0] sector;
   logic guarded;
   assign level = {protect_level_msb, protect_level_mid, protect_level_lsb};
   assign sector = {1'b0, op_addr[sfp_pkg::SECT_MSB:sfp_pkg::SECT_LSB]};

   sfp_guard #(.SECTORS(SECTORS)) u_guard (
      .top_bottom(top_bottom),
      .level(level),
      .sector(sector),
      .guarded(guarded)
   );

   logic accept_r, refuse_r, ok;
   always_comb begin
      ok = 1'b0;
      case (op_kind)
         // program clears bits only, handled by array
         sfp_pkg::SFP_OP_PROGRAM: ok = !guarded;
         // sector erase returns bits to one
         sfp_pkg::SFP_OP_SECTOR_ERASE: ok = !guarded;
         sfp_pkg::SFP_OP_BULK_ERASE: ok = (level == sfp_pkg::LEVEL_NONE);
         default: ok = 1'b0;
      endcase
   end
   // pause does not touch busy cycle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         accept_r <= 1'b0;
         refuse_r <= 1'b0;
      end else if (clk_en) begin
         accept_r <= op_valid && !busy && ok;
         refuse_r <= op_valid && !busy && !ok;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign serial_data_out = dout_r;
   assign serial_data_out_oe = oe_r;
   assign paused = paused_r;
   assign rx_byte = rx_sh_r;
   assign rx_valid = rx_valid_r;
   assign bit_count = bit_cnt_r;
   assign op_accept = accept_r;
   assign op_refuse = refuse_r;
   // sel_rise kept for clarity of reset path
   logic unused_ok;
   assign unused_ok = sel_rise;
endmodule
`default_nettype wire

//--- bench/sfp_chk.sv
`default_nettype none
module sfp_chk #(
   parameter int SECTORS = 64
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic sel_n,
   input wire logic busy,
   input wire logic top_bottom,
   input wire logic protect_level_msb,
   input wire logic protect_level_mid,
   input wire logic protect_level_lsb,
   input wire logic op_valid,
   input wire sfp_pkg::sfp_op_type op_kind,
   input wire logic serial_data_out_oe,
   input wire logic op_accept,
   input wire logic op_refuse,
   input wire logic paused,
   input wire logic [7:0] rx_byte,
   input wire logic [2:0] bit_count
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // ----
   // request helpers
   // ----
   wire logic [2:0] lvl = {protect_level_msb, protect_level_mid, protect_level_lsb};
   wire logic req = op_valid & clk_en & !busy;
   sequence bulk_req;
      req && op_kind == sfp_pkg::SFP_OP_BULK_ERASE;
   endsequence
   sequence prog_req;
      req && op_kind == sfp_pkg::SFP_OP_PROGRAM;
   endsequence
   chk_bulk_refused: assert property (bulk_req ##0 lvl != 3'h0 |=> op_refuse && !op_accept)
      else $error("bulk erase not refused");
   chk_bulk_taken: assert property (bulk_req ##0 lvl == 3'h0 |=> op_accept && !op_refuse)
      else $error("bulk erase not accepted");
   chk_all_guarded: assert property (prog_req ##0 lvl == 3'h7 && (SECTORS == 64 || !top_bottom) |=> op_refuse)
      else $error("program into full span not refused");
   chk_none_guarded: assert property (prog_req ##0 lvl == 3'h0 |=> op_accept && !op_refuse)
      else $error("program with level zero not accepted");
   chk_busy_ignored: assert property (clk_en && op_valid && busy |=> !op_accept && !op_refuse)
      else $error("request answered while busy");
   chk_pause_float: assert property (paused [*2] |-> !serial_data_out_oe)
      else $error("output driven while paused");
   chk_pause_frozen: assert property (paused [*2] |-> $stable(rx_byte) && $stable(bit_count))
      else $error("interface state moved while paused");
   chk_deselect_clear: assert property (sel_n [*6] |-> !paused && bit_count == 3'h0)
      else $error("deselect did not clear interface");
endmodule
bind sfp_top sfp_chk #(.SECTORS(SECTORS)) chk_u (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
   .sel_n(sel_n), .busy(busy), .top_bottom(top_bottom), .protect_level_msb(protect_level_msb),
   .protect_level_mid(protect_level_mid), .protect_level_lsb(protect_level_lsb), .op_valid(op_valid),
   .op_kind(op_kind), .serial_data_out_oe(serial_data_out_oe), .op_accept(op_accept), .op_refuse(op_refuse),
   .paused(paused), .rx_byte(rx_byte), .bit_count(bit_count));
`default_nettype wire

//--- bench/sfp_host.sv
`default_nettype none
module sfp_host (
   output logic sel_n,
   output logic sclk,
   output logic pause_n,
   output logic serial_data_in,
   input wire logic serial_data_out,
   input wire logic serial_data_out_oe,
   output logic [7:0] got
);
   timeunit 1ns;
   timeprecision 1ps;
   // link idle: clock parked low outside frames
   initial begin
      sel_n = 1'b1;
      sclk = 1'b0;
      pause_n = 1'b1;
      serial_data_in = 1'b0;
      got = 8'h00;
   end
   always @(posedge sclk) if (!sel_n && serial_data_out_oe) got <= {got[6:0], serial_data_out};
   task automatic put(input logic [7:0] b, input int n);
      for (int i = 7; i > 7 - n; i--) begin
         serial_data_in = b[i];
         #80 sclk = 1'b1;
         #80 sclk = 1'b0;
      end
   endtask
   task automatic clk(input logic c);
      #80 sclk = c;
   endtask
   // released data line shows the inverse of its last value
   task automatic sel(input logic s);
      #80 sel_n = s;
      if (s) serial_data_in = ~serial_data_in;
   endtask
   task automatic hold(input logic p);
      pause_n = !p;
      #200;
   endtask
endmodule
`default_nettype wire

//--- bench/sfp_top_tb.sv
`default_nettype none
module sfp_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, resetn = 1'b0, top_bottom = 1'b0, busy = 1'b0, op_valid = 1'b0;
   logic [2:0] lvl = 3'h0;
   sfp_pkg::sfp_op_type op_kind = sfp_pkg::SFP_OP_NONE;
   logic [21:0] op_addr = 22'h000000;
   logic [7:0] rx_last = 8'h00;
   logic clk_en = 1'b1;
   logic [7:0] tx_byte = 8'h96;
   wire logic sel_n, sclk, pause_n, sdi, sdo, sdo_oe, op_accept, op_refuse, paused, rx_valid;
   wire logic [7:0] rx_byte, got;
   wire logic [2:0] bit_count;
   int mismatches = 0, compares = 0, cycles = 0;
   always #10 core_clk = ~core_clk;
   sfp_top dut_u (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .sel_n(sel_n), .sclk(sclk),
      .pause_n(pause_n), .serial_data_in(sdi), .serial_data_out(sdo), .serial_data_out_oe(sdo_oe),
      .top_bottom(top_bottom), .protect_level_msb(lvl[2]), .protect_level_mid(lvl[1]),
      .protect_level_lsb(lvl[0]), .busy(busy), .tx_byte(tx_byte), .op_valid(op_valid), .op_kind(op_kind),
      .op_addr(op_addr), .op_accept(op_accept), .op_refuse(op_refuse), .paused(paused), .rx_byte(rx_byte),
      .rx_valid(rx_valid), .bit_count(bit_count));
   sfp_host host_u (.sel_n(sel_n), .sclk(sclk), .pause_n(pause_n), .serial_data_in(sdi),
      .serial_data_out(sdo), .serial_data_out_oe(sdo_oe), .got(got));
   // ----
   // helpers
   // ----
   // keep the last received byte; a hang is cut at 5000 cycles
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (rx_valid === 1'b1) rx_last <= rx_byte;
      if (cycles == 5000) begin
         mismatches++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // level bits change with the request itself, so decode must be immediate
   task automatic op(input sfp_pkg::sfp_op_type k, input logic t, input logic [2:0] l, input logic [5:0] s,
                     input logic ok);
      @(posedge core_clk);
      op_valid <= 1'b1;
      op_kind <= k;
      top_bottom <= t;
      lvl <= l;
      op_addr <= {s, 16'h8001};
      @(posedge core_clk);
      op_valid <= 1'b0;
      #1 check({6'h00, op_accept, op_refuse}, {6'h00, ok & !busy, !ok & !busy});
   endtask
   function automatic logic guarded(input logic t, input logic [2:0] l, input int s);
      int n;
      n = (l == 3'h7) ? 64 : (l == 3'h0) ? 0 : (1 << (l - 3'h1));
      return t ? (s < n) : (s >= 64 - n);
   endfunction
   initial begin
      repeat (3) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (6) @(posedge core_clk);
      for (int t = 0; t < 2; t++)
         for (int l = 0; l < 8; l++)
            for (int s = 0; s < 64; s++)
               op(s[0] ? sfp_pkg::SFP_OP_SECTOR_ERASE : sfp_pkg::SFP_OP_PROGRAM, t[0], l[2:0], s[5:0],
                  !guarded(t[0], l[2:0], s));
      for (int l = 0; l < 8; l++) op(sfp_pkg::SFP_OP_BULK_ERASE, 1'b0, l[2:0], 6'h00, l == 0);
      op(sfp_pkg::SFP_OP_NONE, 1'b0, 3'h0, 6'h00, 1'b0);
      @(posedge core_clk) busy <= 1'b1;
      op(sfp_pkg::SFP_OP_PROGRAM, 1'b0, 3'h0, 6'h05, 1'b1);
      busy <= 1'b0;
      // clock enable low: an allowed request must not be answered
      @(posedge core_clk);
      clk_en <= 1'b0;
      op_valid <= 1'b1;
      op_kind <= sfp_pkg::SFP_OP_PROGRAM;
      lvl <= 3'h0;
      repeat (2) @(posedge core_clk);
      #1 check({6'h00, op_accept, op_refuse}, 8'h00);
      op_valid <= 1'b0;
      clk_en <= 1'b1;
      // serial pause sequence: fifth bit leaves sclk high
      host_u.sel(1'b0);
      host_u.put(8'hA5, 4);
      host_u.clk(1'b1);
      host_u.hold(1'b1);
      check({7'h00, paused}, 8'h00);
      host_u.clk(1'b0);
      #200 check({6'h00, paused, sdo_oe}, 8'h02);
      host_u.put(8'hFF, 2);
      check({5'h00, bit_count}, 8'h05);
      host_u.clk(1'b1);
      host_u.hold(1'b0);
      check({7'h00, paused}, 8'h01);
      host_u.clk(1'b0);
      #200 check({7'h00, paused}, 8'h00);
      host_u.put(8'hA0, 3);
      #400 check(rx_last, 8'hA5);
      host_u.put(8'hF0, 3);
      host_u.hold(1'b1);
      check({7'h00, paused}, 8'h01);
      host_u.sel(1'b1);
      #200 check({4'h0, paused, bit_count}, 8'h00);
      host_u.hold(1'b0);
      tx_byte <= 8'h69;
      host_u.sel(1'b0);
      host_u.put(8'h3C, 8);
      #400 check(rx_last, 8'h3C);
      check(got, 8'h69);
      host_u.sel(1'b1);
      give_verdict();
   end
endmodule
`default_nettype wire
